// ### core/mrc_ctrl.sv
// Measurement run control with AHB-Lite register slave
`timescale 1ns/1ps
module mrc_ctrl #(
    parameter int TW = 32
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    input  wire logic        scan_frame_ready_i,
    output logic [31:0]      hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic             arm_o,
    output logic             fifo_clear_o,
    output logic             irq_o
);
    mrc_pkg::mrc_state_e state_ff, nxt_state;
    mrc_pkg::mrc_cmd_s   cmd;
    logic [2:0]    ctrl_ff, nxt_ctrl;
    logic [TW-1:0] coltime_ff, nxt_coltime;
    logic [TW-1:0] brk_col_ff, nxt_brk_col, brk_rep_ff, nxt_brk_rep;
    logic [31:0]   result_ff, nxt_result;
    logic          seq_run_ff, nxt_seq_run, seq_wait_ff, nxt_seq_wait;
    logic          cur_bank_ff, nxt_cur_bank;
    logic [1:0]    bank_arm_ff, nxt_bank_arm;
    logic          arm_ff, nxt_arm, finished_ff, nxt_finished;
    logic          scan_frame_ready_flag_ff, nxt_scan_frame_ready_flag;
    logic          fifo_clr_ff, nxt_fifo_clr;
    logic [mrc_pkg::IRQ_W-1:0] irq_stat_ff, nxt_irq_stat, irq_mask_ff, nxt_irq_mask;
    logic [mrc_pkg::IRQ_W-1:0] ev;
    logic          irq_ff;
    logic          tmr_load, tmr_run;
    logic [TW-1:0] rep_cnt, col_cnt;
    logic          col_zero;
    logic          dph_wr_ff, dph_rd_ff, nxt_dph_wr, nxt_dph_rd;
    logic [7:0]    dph_addr_ff, nxt_dph_addr;
    logic [31:0]   rdata_ff, nxt_rdata;
    logic          wr;
    logic [8:0]    status;

    function automatic logic wr_at(input logic [7:0] a, input logic [7:0] r, input logic w);
        return w && (a == r);
    endfunction

    // Repeat timer counts down from all ones; loaded only on a start with neither sequencer nor FIFO mode
    mrc_timer #(.W(TW)) u_rep (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .load_i    (tmr_load),
        .value_i   ({TW{1'b1}}),
        .run_i     (tmr_run),
        .count_o   (rep_cnt),
        .zero_o    ()
    );
    mrc_timer #(.W(TW)) u_col (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .load_i    (tmr_load),
        .value_i   (coltime_ff),
        .run_i     (tmr_run),
        .count_o   (col_cnt),
        .zero_o    (col_zero)
    );

    // Bus: address phase captured, data phase handled next cycle, zero wait
    always_comb begin
        logic ap;
        ap = hsel_i && hready_i &&
             ((htrans_i == mrc_pkg::HTRANS_NONSEQ) || (htrans_i == mrc_pkg::HTRANS_SEQ));
        nxt_dph_wr   = ap && hwrite_i;
        nxt_dph_rd   = ap && !hwrite_i;
        nxt_dph_addr = ap ? haddr_i[7:0] : dph_addr_ff;
    end

    assign wr = dph_wr_ff;
    assign cmd.start   = wr_at(dph_addr_ff, mrc_pkg::ADDR_CMD, wr) && hwdata_i[mrc_pkg::CMD_START];
    assign cmd.pause   = wr_at(dph_addr_ff, mrc_pkg::ADDR_CMD, wr) && hwdata_i[mrc_pkg::CMD_PAUSE];
    assign cmd.restart = wr_at(dph_addr_ff, mrc_pkg::ADDR_CMD, wr)
                         && hwdata_i[mrc_pkg::CMD_RESTART];
    assign cmd.stop    = wr_at(dph_addr_ff, mrc_pkg::ADDR_CMD, wr) && hwdata_i[mrc_pkg::CMD_STOP];

    assign status = {bank_arm_ff, cur_bank_ff, finished_ff, (state_ff == mrc_pkg::MRC_PAUSE),
                     arm_ff, seq_wait_ff, seq_run_ff, ctrl_ff[mrc_pkg::CTRL_SEQ_EN]};

    // Run control; command priority stop, start, pause, restart
    always_comb begin
        nxt_state    = state_ff;
        nxt_ctrl     = wr_at(dph_addr_ff, mrc_pkg::ADDR_CTRL, wr) ? hwdata_i[2:0] : ctrl_ff;
        nxt_coltime  = wr_at(dph_addr_ff, mrc_pkg::ADDR_COLTIME, wr) ? TW'(hwdata_i)
                                                                     : coltime_ff;
        nxt_brk_col  = brk_col_ff;
        nxt_brk_rep  = brk_rep_ff;
        nxt_result   = result_ff;
        nxt_seq_run  = seq_run_ff;
        nxt_seq_wait = seq_wait_ff;
        nxt_cur_bank = cur_bank_ff;
        nxt_bank_arm = bank_arm_ff;
        nxt_arm      = arm_ff;
        nxt_finished = finished_ff;
        nxt_fifo_clr = 1'b0;
        nxt_scan_frame_ready_flag = scan_frame_ready_flag_ff | scan_frame_ready_i;
        tmr_load     = 1'b0;
        tmr_run      = (state_ff == mrc_pkg::MRC_RUN) && !ctrl_ff[mrc_pkg::CTRL_SEQ_EN];
        ev           = '0;
        if (cmd.stop) begin
            if (ctrl_ff[mrc_pkg::CTRL_SEQ_EN]) begin
                nxt_seq_run  = 1'b0;
                nxt_seq_wait = 1'b0;
                nxt_bank_arm = '0;
                // A frame event in the same cycle beats the clear
                nxt_scan_frame_ready_flag = scan_frame_ready_i;
            end else if (!ctrl_ff[mrc_pkg::CTRL_FIFO]) begin
                nxt_brk_col = col_cnt;
                nxt_brk_rep = rep_cnt;
            end
            nxt_arm   = 1'b0;
            tmr_run   = 1'b0;
            nxt_state = mrc_pkg::MRC_IDLE;
        end else if (cmd.start) begin
            nxt_finished = 1'b0;
            if (ctrl_ff[mrc_pkg::CTRL_FIFO]) begin
                nxt_fifo_clr = 1'b1;
                nxt_arm      = 1'b0;
                nxt_state    = mrc_pkg::MRC_CLEAR;
            end else if (!ctrl_ff[mrc_pkg::CTRL_SEQ_EN]) begin
                tmr_load  = 1'b1;
                nxt_arm   = 1'b1;
                nxt_state = mrc_pkg::MRC_RUN;
            end else if (!seq_run_ff) begin
                nxt_seq_run = 1'b1;
                if (!ctrl_ff[mrc_pkg::CTRL_SEQ_ONE]) begin
                    nxt_bank_arm[~cur_bank_ff] = 1'b1;
                end
                nxt_bank_arm[cur_bank_ff] = 1'b1;
                nxt_seq_wait = 1'b0;
                nxt_arm      = 1'b1;
                nxt_state    = mrc_pkg::MRC_RUN;
            end else begin
                nxt_bank_arm[cur_bank_ff] = 1'b1;
                nxt_cur_bank = ~cur_bank_ff;
                nxt_seq_wait = 1'b0;
            end
        end else if (cmd.pause) begin
            if (ctrl_ff[mrc_pkg::CTRL_SEQ_EN]) begin
                nxt_result = mrc_pkg::RES_ERROR;
                ev[mrc_pkg::IRQ_ERROR] = 1'b1;
            end else if (state_ff == mrc_pkg::MRC_RUN) begin
                tmr_run    = 1'b0;
                nxt_arm    = 1'b0;
                nxt_state  = mrc_pkg::MRC_PAUSE;
                nxt_result = mrc_pkg::RES_OK;
            end else begin
                nxt_result = mrc_pkg::RES_FINISHED;
            end
        end else if (cmd.restart) begin
            if (ctrl_ff[mrc_pkg::CTRL_SEQ_EN]) begin
                nxt_result = mrc_pkg::RES_ERROR;
                ev[mrc_pkg::IRQ_ERROR] = 1'b1;
            end else if (state_ff == mrc_pkg::MRC_PAUSE) begin
                nxt_arm    = 1'b1;
                nxt_state  = mrc_pkg::MRC_RUN;
                nxt_result = mrc_pkg::RES_OK;
            end
        end else begin
            case (state_ff)
                mrc_pkg::MRC_CLEAR: begin
                    nxt_arm   = 1'b1;
                    nxt_state = mrc_pkg::MRC_RUN;
                end
                mrc_pkg::MRC_RUN: begin
                    if (!ctrl_ff[mrc_pkg::CTRL_SEQ_EN] && !ctrl_ff[mrc_pkg::CTRL_FIFO]
                        && col_zero) begin
                        nxt_arm      = 1'b0;
                        nxt_finished = 1'b1;
                        nxt_state    = mrc_pkg::MRC_IDLE;
                        ev[mrc_pkg::IRQ_FINISH] = 1'b1;
                    end
                    // Sequencer waits when the bank it would move to is unarmed
                    if (seq_run_ff && !bank_arm_ff[~cur_bank_ff]) begin
                        nxt_seq_wait = 1'b1;
                    end
                end
                mrc_pkg::MRC_IDLE, mrc_pkg::MRC_PAUSE: begin
                end
                default: nxt_state = mrc_pkg::MRC_IDLE;
            endcase
        end
        ev[mrc_pkg::IRQ_SCAN] = scan_frame_ready_i;
        // Set beats write-one clear
        nxt_irq_stat = irq_stat_ff;
        if (wr_at(dph_addr_ff, mrc_pkg::ADDR_IRQ_STAT, wr)) begin
            nxt_irq_stat = irq_stat_ff & ~hwdata_i[mrc_pkg::IRQ_W-1:0];
        end
        nxt_irq_stat = nxt_irq_stat | ev;
        nxt_irq_mask = wr_at(dph_addr_ff, mrc_pkg::ADDR_IRQ_MASK, wr)
                       ? hwdata_i[mrc_pkg::IRQ_W-1:0] : irq_mask_ff;
    end

    // Read mux; unmapped reads return zero
    always_comb begin
        nxt_rdata = rdata_ff;
        if (nxt_dph_rd) begin
            case (haddr_i[7:0])
                mrc_pkg::ADDR_CTRL:     nxt_rdata = 32'(ctrl_ff);
                mrc_pkg::ADDR_STATUS:   nxt_rdata = 32'(status);
                mrc_pkg::ADDR_RESULT:   nxt_rdata = result_ff;
                mrc_pkg::ADDR_COLTIME:  nxt_rdata = 32'(coltime_ff);
                mrc_pkg::ADDR_REPTIME:  nxt_rdata = 32'(rep_cnt);
                mrc_pkg::ADDR_COLNOW:   nxt_rdata = 32'(col_cnt);
                mrc_pkg::ADDR_BRK_COL:  nxt_rdata = 32'(brk_col_ff);
                mrc_pkg::ADDR_BRK_REP:  nxt_rdata = 32'(brk_rep_ff);
                mrc_pkg::ADDR_IRQ_STAT: nxt_rdata = 32'(irq_stat_ff);
                mrc_pkg::ADDR_IRQ_MASK: nxt_rdata = 32'(irq_mask_ff);
                mrc_pkg::ADDR_SCAN:     nxt_rdata = 32'(scan_frame_ready_flag_ff);
                default:                nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_ff    <= mrc_pkg::MRC_IDLE;
            ctrl_ff     <= '0;
            coltime_ff  <= '0;
            brk_col_ff  <= '0;
            brk_rep_ff  <= '0;
            result_ff   <= '0;
            seq_run_ff  <= 1'b0;
            seq_wait_ff <= 1'b0;
            cur_bank_ff <= 1'b0;
            bank_arm_ff <= '0;
            arm_ff      <= 1'b0;
            finished_ff <= 1'b0;
            fifo_clr_ff <= 1'b0;
            scan_frame_ready_flag_ff <= 1'b0;
            irq_stat_ff <= '0;
            irq_mask_ff <= '0;
            irq_ff      <= 1'b0;
            dph_wr_ff   <= 1'b0;
            dph_rd_ff   <= 1'b0;
            dph_addr_ff <= '0;
            rdata_ff    <= '0;
        end else begin
            state_ff    <= nxt_state;
            ctrl_ff     <= nxt_ctrl;
            coltime_ff  <= nxt_coltime;
            brk_col_ff  <= nxt_brk_col;
            brk_rep_ff  <= nxt_brk_rep;
            result_ff   <= nxt_result;
            seq_run_ff  <= nxt_seq_run;
            seq_wait_ff <= nxt_seq_wait;
            cur_bank_ff <= nxt_cur_bank;
            bank_arm_ff <= nxt_bank_arm;
            arm_ff      <= nxt_arm;
            finished_ff <= nxt_finished;
            fifo_clr_ff <= nxt_fifo_clr;
            scan_frame_ready_flag_ff <= nxt_scan_frame_ready_flag;
            irq_stat_ff <= nxt_irq_stat;
            irq_mask_ff <= nxt_irq_mask;
            irq_ff      <= |(nxt_irq_stat & nxt_irq_mask);
            dph_wr_ff   <= nxt_dph_wr;
            dph_rd_ff   <= nxt_dph_rd;
            dph_addr_ff <= nxt_dph_addr;
            rdata_ff    <= nxt_rdata;
        end
    end

    assign hrdata_o     = rdata_ff;
    assign hreadyout_o  = 1'b1;
    assign hresp_o      = 1'b0;
    assign arm_o        = arm_ff;
    assign fifo_clear_o = fifo_clr_ff;
    assign irq_o        = irq_ff;

    start_norm_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !cmd.stop && cmd.start && !ctrl_ff[0] && !ctrl_ff[2]
        |=> arm_o && col_cnt == $past(coltime_ff))
        else $error("start did not load timer and arm");
    seq_one_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !cmd.stop && cmd.start && ctrl_ff == 3'h3 && !seq_run_ff && bank_arm_ff == 2'h0
        |=> $countones(bank_arm_ff) == 1)
        else $error("single bank mode armed both banks");
    seq_idle_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !cmd.stop && cmd.start && ctrl_ff == 3'h1 && !seq_run_ff
        |=> seq_run_ff && bank_arm_ff == 2'h3 && arm_o)
        else $error("idle sequencer start wrong");
    seq_swap_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !cmd.stop && cmd.start && ctrl_ff[0] && !ctrl_ff[2] && seq_run_ff
        |=> cur_bank_ff != $past(cur_bank_ff))
        else $error("bank not swapped");
    fifo_start_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !cmd.stop && cmd.start && ctrl_ff[2] |=> fifo_clear_o && !arm_o ##1 arm_o)
        else $error("fifo start sequence wrong");
    pause_err_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        cmd.pause && ctrl_ff[0] && !cmd.stop && !cmd.start
        |=> result_ff == 32'hffff_ffff && arm_o == $past(arm_o))
        else $error("pause with sequencer not rejected");
    pause_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        state_ff == mrc_pkg::MRC_PAUSE |-> !arm_o && col_cnt == $past(col_cnt))
        else $error("timer moved while paused");
    stop_brk_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        cmd.stop && ctrl_ff == 3'h0 |=> !arm_o && brk_col_ff == $past(col_cnt))
        else $error("stop break time wrong");
    run_finish_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        state_ff == mrc_pkg::MRC_RUN && ctrl_ff == 3'h0 && col_zero && cmd == '0
        |=> !arm_o && finished_ff)
        else $error("timeout did not finish");
endmodule // mrc_ctrl

// ### inc/mrc_pkg.sv
// Package for measurement run control: constants, types and register map
// Operation
// - Start, no sequencer: load timers and arm in the same cycle
// - Start, idle sequencer: start it, arm next bank
// - Single-bank accumulation skips next bank arming
// - Then arm current bank and collect photons
// - Start, running sequencer: arm current, swap banks
// - Start in FIFO mode: clear FIFO, then arm
// - Pause, no sequencer: halt timers, disarm
// - Pause with sequencer enabled is rejected
// - Pause result: zero finished, positive paused, negative error
// - Restart, no sequencer: resume timers, re-arm
// - Restart with sequencer enabled is rejected
// - Stop, no sequencer: disarm, capture break times outside FIFO mode
// - Stop, sequencer enabled: halt sequencer, disarm
// - Stop with sequencer enabled clears frame-ready flag
// - Sequencer status: enabled, running, bank wait bits
package mrc_pkg;
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_CMD      = 8'h04;
    localparam logic [7:0] ADDR_STATUS   = 8'h08;
    localparam logic [7:0] ADDR_RESULT   = 8'h0c;
    localparam logic [7:0] ADDR_COLTIME  = 8'h10;
    localparam logic [7:0] ADDR_REPTIME  = 8'h14;
    localparam logic [7:0] ADDR_COLNOW   = 8'h18;
    localparam logic [7:0] ADDR_BRK_COL  = 8'h1c;
    localparam logic [7:0] ADDR_BRK_REP  = 8'h20;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
    localparam logic [7:0] ADDR_SCAN     = 8'h2c;

    // Control register fields
    localparam int CTRL_SEQ_EN   = 0;
    localparam int CTRL_SEQ_ONE  = 1;
    localparam int CTRL_FIFO     = 2;
    // Command register fields, one-shot
    localparam int CMD_START     = 0;
    localparam int CMD_PAUSE     = 1;
    localparam int CMD_RESTART   = 2;
    localparam int CMD_STOP      = 3;
    // Status fields
    localparam int ST_SEQ_EN     = 0;
    localparam int ST_SEQ_RUN    = 1;
    localparam int ST_SEQ_WAIT   = 2;
    localparam int ST_ARMED      = 3;
    localparam int ST_PAUSED     = 4;
    localparam int ST_FINISHED   = 5;
    localparam int ST_CUR_BANK   = 6;
    localparam int ST_ARM_BANK0  = 7;
    localparam int ST_ARM_BANK1  = 8;
    // Interrupt event bits
    localparam int IRQ_FINISH    = 0;
    localparam int IRQ_ERROR     = 1;
    localparam int IRQ_SCAN      = 2;
    localparam int IRQ_W         = 3;

    localparam logic [31:0] RES_FINISHED = 32'h0000_0000;
    localparam logic [31:0] RES_OK       = 32'h0000_0001;
    localparam logic [31:0] RES_ERROR    = 32'hffff_ffff;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ    = 2'h3;

    typedef enum logic [3:0] {
        MRC_IDLE  = 4'h1,
        MRC_CLEAR = 4'h2,
        MRC_RUN   = 4'h4,
        MRC_PAUSE = 4'h8
    } mrc_state_e;

    typedef struct packed {
        logic start;
        logic pause;
        logic restart;
        logic stop;
    } mrc_cmd_s;
endpackage

// ### core/mrc_timer.sv
// Down counter for the repeat and collection timers
`timescale 1ns/1ps
module mrc_timer #(
    parameter int W = 32
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] value_i,
    input  wire logic         run_i,
    output logic [W-1:0]      count_o,
    output logic              zero_o
);
    logic [W-1:0] count_ff;
    logic [W-1:0] nxt_count;

    always_comb begin
        nxt_count = count_ff;
        if (load_i) begin
            nxt_count = value_i;
        end else if (run_i && (count_ff != '0)) begin
            nxt_count = count_ff - W'(1);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end

    assign count_o = count_ff;
    assign zero_o  = (count_ff == '0);
endmodule // mrc_timer

// ### bench/mrc_host.sv
// Host model: AHB-Lite master issuing run-control register accesses
`timescale 1ns/1ps
module mrc_host (
    input  wire logic        ref_clk_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hrdata_i,
    output logic             hsel_o,
    output logic [31:0]      haddr_o,
    output logic [1:0]       htrans_o,
    output logic             hwrite_o,
    output logic [2:0]       hsize_o,
    output logic [31:0]      hwdata_o
);
    initial begin
        hsel_o = 1'b0;
        haddr_o = 32'h0;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hsize_o = 3'h2;
        hwdata_o = 32'h0;
    end

    // Single word transfer; no wait count assumed, the bench timeout ends a hang
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge ref_clk_i);
        hsel_o <= 1'b1;
        haddr_o <= {24'h0, a};
        htrans_o <= mrc_pkg::HTRANS_NONSEQ;
        hwrite_o <= w;
        do @(posedge ref_clk_i); while (hready_i !== 1'b1);
        hsel_o <= 1'b0;
        htrans_o <= 2'h0;
        // Reads get scrambled write data so stale values never look valid
        hwdata_o <= w ? d : ~hwdata_o;
        do @(posedge ref_clk_i); while (hready_i !== 1'b1);
        q = hrdata_i;
    endtask
endmodule // mrc_host

// ### bench/measurement_run_control_tb_top.sv
// Testbench for measurement run control with host model and reference checks
`timescale 1ns/1ps
module measurement_run_control_tb_top;
    logic        ref_clk_i;
    logic        rst_i;
    logic        hsel, hwrite, hready, hresp, scan, arm, fclr, irq;
    logic [31:0] haddr, hwdata, hrdata, q, q2;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        b;
    int          miscompares, tests_run, seed, n, cnt;

    mrc_ctrl mrc_ctrl_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
        .hwdata_i(hwdata), .hready_i(hready), .scan_frame_ready_i(scan),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .arm_o(arm),
        .fifo_clear_o(fclr), .irq_o(irq));

    mrc_host mrc_host_inst (.ref_clk_i(ref_clk_i), .hready_i(hready),
        .hrdata_i(hrdata), .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
        .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));

    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic final_report();
        $display("Checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] t;
        mrc_host_inst.xfer(1'b1, a, d, t);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        mrc_host_inst.xfer(1'b0, a, 32'h0, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] t;
        rd(a, t);
        chk(nm, t, e);
    endtask

    // Commands are one-shot bits; the settled output is looked at 1 ns on
    task automatic cmd(input int bit_no);
        wr(mrc_pkg::ADDR_CMD, 32'h1 << bit_no);
        #1;
    endtask

    // Whole run is about two hundred cycles; this leaves wide margin
    initial begin
        #400000;
        miscompares++;
        final_report();
    end

    initial begin
        seed = 93;
        miscompares = 0;
        tests_run = 0;
        rst_i = 1'b1;
        scan = 1'b0;
        repeat (6) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rdc(mrc_pkg::ADDR_STATUS, 32'h0, "status reset");
        wr(8'h40, 32'hffff_ffff);
        rdc(8'h40, 32'h0, "unmapped");
        chk("hresp okay", {31'h0, hresp}, 32'h0);
        chk("arm reset", {31'h0, arm}, 32'h0);
        $display("test reset done");

        n = 8 + ($unsigned($random(seed)) % 16);
        wr(mrc_pkg::ADDR_IRQ_MASK, 32'h7);
        wr(mrc_pkg::ADDR_CTRL, 32'h0);
        wr(mrc_pkg::ADDR_COLTIME, n);
        cmd(mrc_pkg::CMD_START);
        chk("arm start", {31'h0, arm}, 32'h1);
        cnt = 0;
        while (arm === 1'b1 && cnt < 200) begin
            @(posedge ref_clk_i);
            #1;
            cnt++;
        end
        chk("run length", {31'h0, cnt >= n - 1 && cnt <= n + 2}, 32'h1);
        @(posedge ref_clk_i);
        #1;
        chk("irq finish", {31'h0, irq}, 32'h1);
        rd(mrc_pkg::ADDR_STATUS, q);
        chk("finished", {31'h0, q[mrc_pkg::ST_FINISHED]}, 32'h1);
        cmd(mrc_pkg::CMD_PAUSE);
        rdc(mrc_pkg::ADDR_RESULT, mrc_pkg::RES_FINISHED, "pause done");
        wr(mrc_pkg::ADDR_IRQ_STAT, 32'h1);
        @(posedge ref_clk_i);
        #1;
        chk("irq clear", {31'h0, irq}, 32'h0);
        $display("test timed run done");

        wr(mrc_pkg::ADDR_COLTIME, 32'd400);
        cmd(mrc_pkg::CMD_START);
        cmd(mrc_pkg::CMD_PAUSE);
        chk("arm pause", {31'h0, arm}, 32'h0);
        rdc(mrc_pkg::ADDR_RESULT, mrc_pkg::RES_OK, "pause ok");
        rd(mrc_pkg::ADDR_COLNOW, q);
        rdc(mrc_pkg::ADDR_COLNOW, q, "timer halted");
        cmd(mrc_pkg::CMD_RESTART);
        chk("arm restart", {31'h0, arm}, 32'h1);
        rd(mrc_pkg::ADDR_COLNOW, q);
        rd(mrc_pkg::ADDR_COLNOW, q2);
        chk("timer resumed", {31'h0, q2 < q}, 32'h1);
        cmd(mrc_pkg::CMD_STOP);
        chk("arm stop", {31'h0, arm}, 32'h0);
        rd(mrc_pkg::ADDR_BRK_COL, q);
        chk("break col", {31'h0, q != 0 && q < 400}, 32'h1);
        rd(mrc_pkg::ADDR_BRK_REP, q);
        chk("break rep", {31'h0, q != 0 && q != 32'hffff_ffff}, 32'h1);
        $display("test pause done");

        wr(mrc_pkg::ADDR_CTRL, 32'h1 << mrc_pkg::CTRL_SEQ_EN);
        cmd(mrc_pkg::CMD_START);
        rd(mrc_pkg::ADDR_STATUS, q);
        b = q[mrc_pkg::ST_CUR_BANK];
        chk("seq start", q & 32'h18f, 32'h18b);
        cmd(mrc_pkg::CMD_PAUSE);
        chk("arm kept", {31'h0, arm}, 32'h1);
        rdc(mrc_pkg::ADDR_RESULT, mrc_pkg::RES_ERROR, "pause refused");
        // Result stays at -1, so only the error event shows the restart refusal
        wr(mrc_pkg::ADDR_IRQ_STAT, 32'h1 << mrc_pkg::IRQ_ERROR);
        rd(mrc_pkg::ADDR_IRQ_STAT, q);
        chk("irq error clear", {31'h0, q[mrc_pkg::IRQ_ERROR]}, 32'h0);
        cmd(mrc_pkg::CMD_RESTART);
        rdc(mrc_pkg::ADDR_RESULT, mrc_pkg::RES_ERROR, "restart refused");
        rd(mrc_pkg::ADDR_IRQ_STAT, q);
        chk("irq error", {31'h0, q[mrc_pkg::IRQ_ERROR], irq}, 32'h3);
        wr(mrc_pkg::ADDR_IRQ_MASK, 32'h0);
        @(posedge ref_clk_i);
        #1;
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(mrc_pkg::ADDR_IRQ_STAT, 32'hffff_ffff);
        rdc(mrc_pkg::ADDR_IRQ_STAT, 32'h0, "irq w1c");
        cmd(mrc_pkg::CMD_START);
        rd(mrc_pkg::ADDR_STATUS, q);
        chk("bank swap", {31'h0, q[mrc_pkg::ST_CUR_BANK]}, {31'h0, ~b});
        @(posedge ref_clk_i);
        scan <= 1'b1;
        @(posedge ref_clk_i);
        scan <= 1'b0;
        rdc(mrc_pkg::ADDR_SCAN, 32'h1, "scan flag");
        cmd(mrc_pkg::CMD_STOP);
        chk("arm seq stop", {31'h0, arm}, 32'h0);
        rd(mrc_pkg::ADDR_STATUS, q);
        chk("seq halted", q & 32'h3, 32'h1);
        rdc(mrc_pkg::ADDR_SCAN, 32'h0, "scan cleared");
        wr(mrc_pkg::ADDR_CTRL, 32'h3);
        cmd(mrc_pkg::CMD_START);
        rd(mrc_pkg::ADDR_STATUS, q);
        chk("single bank", {30'h0, q[8] ^ q[7], q[2]}, 32'h3);
        cmd(mrc_pkg::CMD_STOP);
        $display("test sequencer done");

        // Pause and restart are never sent in this mode
        wr(mrc_pkg::ADDR_CTRL, 32'h1 << mrc_pkg::CTRL_FIFO);
        cmd(mrc_pkg::CMD_START);
        chk("fifo clear", {30'h0, fclr, arm}, 32'h2);
        @(posedge ref_clk_i);
        #1;
        chk("fifo arm", {30'h0, fclr, arm}, 32'h1);
        cmd(mrc_pkg::CMD_STOP);
        $display("test fifo done");
        final_report();
    end
endmodule // measurement_run_control_tb_top
